// ### logic/ddp_regs.svh
`ifndef DDP_REGS_SVH
`define DDP_REGS_SVH

// Register indices; byte address is four times the index
`define DDP_AUX_IDX        8'hA2
`define DDP_DATA_POINTER_ZERO_IDX      8'hB0
`define DDP_DATA_POINTER_ONE_IDX      8'hB1

// Field positions of aux_control_one
`define DDP_SEL_BIT        0
`define DDP_ZERO_BIT       2
`define DDP_FLAG_BIT       3
`define DDP_BOOT_BIT       5

// Bits that hold state; all others read as zero
`define DDP_AUX_MASK       8'h29
`define DDP_AUX_RST        8'h00

// Boot flash window in code space
`define DDP_BOOT_BASE      16'hF800

// Cycles for the strap to pass the synchroniser
`define DDP_STRAP_SETTLE   2'h2

// Avalon response codes
`define DDP_RESP_OK        2'h0
`define DDP_RESP_SLVERR    2'h2

`define DDP_PTR_RST        16'h0000
`define DDP_WORD_ZERO      32'h0000_0000

`endif

// ### logic/ddp_pkg.sv
package ddp_pkg;

    typedef enum logic [0:0] {
        DDP_IDLE = 1'b0,
        DDP_ACK  = 1'b1
    } ddp_bus_state_t;

    // Pointer operation from the core datapath
    typedef struct packed {
        logic        load;
        logic        inc;
        logic [15:0] value;
    } ddp_ptr_op_t;

    // Pointer write from the register bus
    typedef struct packed {
        logic        wr0;
        logic        wr1;
        logic [1:0]  be;
        logic [15:0] data;
    } ddp_ptr_wr_t;

    typedef struct packed {
        logic [15:0] p0;
        logic [15:0] p1;
        logic [15:0] sel_addr;
    } ddp_ptr_state_t;

    typedef struct packed {
        ddp_bus_state_t bus_st;
        logic [31:0]    rdata;
        logic [1:0]     resp;
        logic [7:0]     aux;
        logic           strap_s1;
        logic           strap_s2;
        logic [1:0]     strap_cnt;
        logic           strap_done;
        logic           boot_hit;
    } ddp_top_state_t;

endpackage

// ### logic/ddp_ptr_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddp_regs.svh"

module ddp_ptr_pair
    import ddp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        sel_d,
    input  wire ddp_ptr_op_t op,
    input  wire ddp_ptr_wr_t bus_wr,
    output logic [15:0]      ptr0,
    output logic [15:0]      ptr1,
    output logic [15:0]      sel_addr
);

    ddp_ptr_state_t st_q;
    ddp_ptr_state_t st_d;

    function automatic logic [15:0] ddp_apply_op(
        input logic [15:0] cur,
        input ddp_ptr_op_t o
    );
        logic [15:0] r;
        r = cur;
        if (o.load) begin
            r = o.value;
        end else if (o.inc) begin
            r = 16'(cur + 16'h0001);
        end
        return r;
    endfunction

    function automatic logic [15:0] ddp_apply_wr(
        input logic [15:0] cur,
        input ddp_ptr_wr_t w
    );
        logic [15:0] r;
        r = cur;
        if (w.be[0]) begin
            r[7:0] = w.data[7:0];
        end
        if (w.be[1]) begin
            r[15:8] = w.data[15:8];
        end
        return r;
    endfunction

    always_comb begin
        st_d = st_q;
        // Core operations touch the selected pointer only
        if (sel_d) begin
            st_d.p1 = ddp_apply_op(st_q.p1, op);
        end else begin
            st_d.p0 = ddp_apply_op(st_q.p0, op);
        end
        // Bus writes take precedence over a core operation
        if (bus_wr.wr0) begin
            st_d.p0 = ddp_apply_wr(st_q.p0, bus_wr);
        end
        if (bus_wr.wr1) begin
            st_d.p1 = ddp_apply_wr(st_q.p1, bus_wr);
        end
        // Only the selected pointer drives the data address
        st_d.sel_addr = sel_d ? st_d.p1 : st_d.p0;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= '{p0: `DDP_PTR_RST, p1: `DDP_PTR_RST,
                      sel_addr: `DDP_PTR_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign ptr0     = st_q.p0;
    assign ptr1     = st_q.p1;
    assign sel_addr = st_q.sel_addr;

endmodule

`default_nettype wire

// ### logic/ddp_aux_ctrl.sv
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ddp_regs.svh"

module ddp_aux_ctrl
    import ddp_pkg::*;
#(
    parameter int ADDR_W = 10
)(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic [31:0]            readdata,
    output logic [1:0]             response,
    output logic                   waitrequest,
    input  wire ddp_ptr_op_t       ptr_op,
    input  wire logic              aux_inc,
    input  wire logic [15:0]       code_addr,
    input  wire logic              boot_jump_config,
    output logic [15:0]            xdata_addr,
    output logic                   pointer_select,
    output logic                   user_flag_three,
    output logic                   boot_flash_map,
    output logic                   boot_hit
);

    ddp_top_state_t st_q;
    ddp_top_state_t st_d;
    ddp_ptr_wr_t    ptr_wr;
    logic [15:0]    data_pointer_zero;
    logic [15:0]    data_pointer_one;
    logic           bus_req;
    logic           hit_aux;
    logic           hit_p0;
    logic           hit_p1;

    // Byte address match against a register index
    function automatic logic ddp_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [7:0]        idx
    );
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'({idx, 2'b00});
        return addr == byte_addr;
    endfunction

    // Reserved bits and bit 2 always read as zero
    function automatic logic [7:0] ddp_aux_view(
        input logic [7:0] aux
    );
        return aux & `DDP_AUX_MASK;
    endfunction

    assign bus_req = read | write;
    assign hit_aux = ddp_hit(address, `DDP_AUX_IDX);
    assign hit_p0  = ddp_hit(address, `DDP_DATA_POINTER_ZERO_IDX);
    assign hit_p1  = ddp_hit(address, `DDP_DATA_POINTER_ONE_IDX);

    always_comb begin
        st_d = st_q;

        // Two-stage synchroniser on the boot strap pin
        st_d.strap_s1 = boot_jump_config;
        st_d.strap_s2 = st_q.strap_s1;

        // Strap loads bit 5 once the synchroniser has settled
        if (!st_q.strap_done) begin
            if (st_q.strap_cnt == `DDP_STRAP_SETTLE) begin
                st_d.aux[`DDP_BOOT_BIT] = st_q.strap_s2;
                st_d.strap_done         = 1'b1;
            end else begin
                st_d.strap_cnt = 2'(st_q.strap_cnt + 2'h1);
            end
        end

        // Whole-register increment: bit 2 never holds a carry
        if (aux_inc && st_q.strap_done) begin
            st_d.aux = ddp_aux_view(8'(ddp_aux_view(st_q.aux) + 8'h01));
        end

        case (st_q.bus_st)
            DDP_IDLE: begin
                if (bus_req && st_q.strap_done) begin
                    st_d.bus_st = DDP_ACK;
                    st_d.resp   = `DDP_RESP_OK;
                    st_d.rdata  = `DDP_WORD_ZERO;
                    if (hit_aux) begin
                        st_d.rdata[7:0] = ddp_aux_view(st_q.aux);
                    end else if (hit_p0) begin
                        st_d.rdata[15:0] = data_pointer_zero;
                    end else if (hit_p1) begin
                        st_d.rdata[15:0] = data_pointer_one;
                    end else begin
                        st_d.resp = `DDP_RESP_SLVERR;
                    end
                end
            end
            DDP_ACK: begin
                st_d.bus_st = DDP_IDLE;
                // Byte write only; reserved bits stay zero
                if (write && hit_aux && byteenable[0]) begin
                    st_d.aux = ddp_aux_view(writedata[7:0]);
                end
            end
            default: begin
                st_d.bus_st = DDP_IDLE;
            end
        endcase

        // Boot flash decode in the top 2 KB of code space
        st_d.boot_hit = st_d.aux[`DDP_BOOT_BIT] &&
                        (code_addr >= `DDP_BOOT_BASE);
    end

    // Pointer writes from the bus land at the acknowledge edge
    always_comb begin
        ptr_wr      = '0;
        ptr_wr.be   = byteenable[1:0];
        ptr_wr.data = writedata[15:0];
        if (st_q.bus_st == DDP_ACK && write) begin
            ptr_wr.wr0 = hit_p0;
            ptr_wr.wr1 = hit_p1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q.bus_st     <= DDP_IDLE;
            st_q.rdata      <= `DDP_WORD_ZERO;
            st_q.resp       <= `DDP_RESP_OK;
            st_q.aux        <= `DDP_AUX_RST;
            st_q.strap_s1   <= 1'b0;
            st_q.strap_s2   <= 1'b0;
            st_q.strap_cnt  <= 2'h0;
            st_q.strap_done <= 1'b0;
            st_q.boot_hit   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    ddp_ptr_pair u_ptr_pair (
        .core_clk (core_clk),
        .rst      (rst),
        .sel_d    (st_d.aux[`DDP_SEL_BIT]),
        .op       (ptr_op),
        .bus_wr   (ptr_wr),
        .ptr0     (data_pointer_zero),
        .ptr1     (data_pointer_one),
        .sel_addr (xdata_addr)
    );

    assign waitrequest     = (st_q.bus_st != DDP_ACK);
    assign readdata        = st_q.rdata;
    assign response        = st_q.resp;
    assign pointer_select  = st_q.aux[`DDP_SEL_BIT];
    assign user_flag_three = st_q.aux[`DDP_FLAG_BIT];
    assign boot_flash_map  = st_q.aux[`DDP_BOOT_BIT];
    assign boot_hit        = st_q.boot_hit;

endmodule

`default_nettype wire

// ### verification/ddp_aux_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddp_regs.svh"
module ddp_aux_ctrl_sva
    import ddp_pkg::*;
#(
    parameter int ADDR_W = 10
)(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic              read,
    input wire logic              write,
    input wire logic [31:0]       writedata,
    input wire logic [3:0]        byteenable,
    input wire logic [31:0]       readdata,
    input wire logic [1:0]        response,
    input wire logic              waitrequest,
    input wire ddp_ptr_op_t       ptr_op,
    input wire logic              aux_inc,
    input wire logic [15:0]       code_addr,
    input wire logic              boot_jump_config,
    input wire logic [15:0]       xdata_addr,
    input wire logic              pointer_select,
    input wire logic              user_flag_three,
    input wire logic              boot_flash_map,
    input wire logic              boot_hit
);
    localparam logic [ADDR_W-1:0] AUX_A = ADDR_W'({`DDP_AUX_IDX, 2'h0});
    localparam logic [ADDR_W-1:0] P0_A  = ADDR_W'({`DDP_DATA_POINTER_ZERO_IDX, 2'h0});
    localparam logic [ADDR_W-1:0] P1_A  = ADDR_W'({`DDP_DATA_POINTER_ONE_IDX, 2'h0});
    logic bus_wr_ack;
    logic aux_wr_ack;
    assign bus_wr_ack = write && !waitrequest;
    assign aux_wr_ack = bus_wr_ack && address == AUX_A && byteenable[0];

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_aux_wr;
        aux_wr_ack;
    endsequence

    a_wait_one_cycle: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_req_answered: assert property ((read || write) |-> ##[0:8] !waitrequest)
        else $error("bus request not answered");
    a_strap_hold: assert property ($fell(rst) |-> waitrequest [*3])
        else $error("bus served before strap load");
    a_aux_write_takes: assert property (s_aux_wr |=>
        {boot_flash_map, user_flag_three, pointer_select} ==
        $past({writedata[5], writedata[3], writedata[0]}))
        else $error("aux write not applied");
    a_aux_zero_bit: assert property (read && !waitrequest && address == AUX_A
        |-> readdata[`DDP_ZERO_BIT] == 1'b0)
        else $error("aux bit two reads one");
    a_inc_toggles: assert property (aux_inc && !aux_wr_ack |=>
        pointer_select != $past(pointer_select) &&
        user_flag_three == $past(user_flag_three))
        else $error("aux increment wrong");
    a_load_selected: assert property (ptr_op.load && !bus_wr_ack
        |=> xdata_addr == $past(ptr_op.value))
        else $error("pointer load not seen");
    a_inc_selected: assert property (ptr_op.inc && !ptr_op.load && !aux_inc
        && !bus_wr_ack |=> xdata_addr == $past(xdata_addr) + 16'h1)
        else $error("pointer increment wrong");
    a_boot_window: assert property (boot_hit == (boot_flash_map &&
        $past(code_addr) >= `DDP_BOOT_BASE))
        else $error("boot window decode wrong");
    a_unmapped_err: assert property (read && !waitrequest && address != AUX_A
        && address != P0_A && address != P1_A |->
        response == `DDP_RESP_SLVERR && readdata == `DDP_WORD_ZERO)
        else $error("unmapped read not refused");
endmodule
`default_nettype wire

// ### verification/ddp_aux_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddp_regs.svh"
module ddp_aux_ctrl_bench
    import ddp_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  address = '0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = '0;
    logic [3:0]  byteenable = '0;
    ddp_ptr_op_t ptr_op = '0;
    logic        aux_inc = 1'b0;
    logic [15:0] code_addr = '0;
    logic        boot_jump_config = 1'b1;
    logic [31:0] readdata;
    logic [1:0]  response;
    logic        waitrequest;
    logic [15:0] xdata_addr;
    logic        pointer_select;
    logic        user_flag_three;
    logic        boot_flash_map;
    logic        boot_hit;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          err_count = 0;
    int          comparisons = 0;

    ddp_aux_ctrl u_dut (.core_clk, .rst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .response, .waitrequest, .ptr_op, .aux_inc,
        .code_addr, .boot_jump_config, .xdata_addr, .pointer_select,
        .user_flag_three, .boot_flash_map, .boot_hit);

    initial forever #2 core_clk = ~core_clk;

    task automatic chk_val(input string m, input logic [31:0] g, e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic chk_resp(input logic [1:0] g, e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: response %h exp %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= {idx, 2'h0};
        writedata <= d;
        byteenable <= be;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        rs = response;
        read <= 1'b0;
        write <= 1'b0;
        // Let the write land before the caller looks at outputs
        @(negedge core_clk);
    endtask

    // One cycle of core activity, outputs settled on return
    task automatic tick(input logic ai, ld, inc, input logic [15:0] v, ca);
        @(posedge core_clk);
        aux_inc <= ai;
        ptr_op <= '{ld, inc, v};
        code_addr <= ca;
        @(posedge core_clk);
        aux_inc <= 1'b0;
        ptr_op <= '0;
        @(negedge core_clk);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, `DDP_AUX_IDX, 0, 4'h1);
        chk_val("aux reset", rd, 32'h20);
        chk_resp(rs, `DDP_RESP_OK);
        chk_val("sel reset", pointer_select, 0);
        chk_val("map reset", boot_flash_map, 1);
        $display("test reset done");
        bus(1, `DDP_AUX_IDX, 32'h0D, 4'h1);
        bus(1, `DDP_AUX_IDX, 32'h00, 4'h0);
        bus(0, `DDP_AUX_IDX, 0, 4'h1);
        chk_val("aux fields", rd, 32'h09);
        $display("test fields done");
        bus(1, `DDP_DATA_POINTER_ZERO_IDX, 32'h1234, 4'h3);
        bus(1, `DDP_DATA_POINTER_ONE_IDX, 32'hABCD, 4'h3);
        chk_val("sel one", xdata_addr, 32'hABCD);
        tick(1, 0, 0, 0, 0);
        chk_val("sel zero", xdata_addr, 32'h1234);
        chk_val("flag kept", user_flag_three, 1);
        tick(0, 0, 1, 0, 0);
        chk_val("ptr inc", xdata_addr, 32'h1235);
        tick(1, 0, 0, 0, 0);
        chk_val("other ptr", xdata_addr, 32'hABCD);
        tick(0, 1, 0, 16'h5555, 0);
        chk_val("ptr load", xdata_addr, 32'h5555);
        bus(0, `DDP_DATA_POINTER_ZERO_IDX, 0, 4'h3);
        chk_val("ptr0 kept", rd, 32'h1235);
        bus(0, `DDP_AUX_IDX, 0, 4'h1);
        chk_val("aux after inc", rd, 32'h09);
        $display("test pointers done");
        bus(1, `DDP_AUX_IDX, 32'h20, 4'h1);
        chk_val("map set", boot_flash_map, 1);
        tick(0, 0, 0, 0, 16'hF800);
        chk_val("boot low edge", boot_hit, 1);
        tick(0, 0, 0, 0, 16'hF7FF);
        chk_val("below boot", boot_hit, 0);
        tick(0, 0, 0, 0, 16'hFFFF);
        chk_val("boot top", boot_hit, 1);
        bus(1, `DDP_AUX_IDX, 32'h00, 4'h1);
        tick(0, 0, 0, 0, 16'hFFFF);
        chk_val("boot unmapped", boot_hit, 0);
        $display("test boot done");
        bus(1, 8'h10, 32'hFF, 4'hF);
        bus(0, 8'h10, 0, 4'hF);
        chk_val("unmapped", rd, 0);
        chk_resp(rs, `DDP_RESP_SLVERR);
        $display("test unmapped done");
        // Mid-run reset with the strap low: bit 5 must follow it
        @(posedge core_clk);
        rst <= 1'b1;
        boot_jump_config <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        bus(0, `DDP_AUX_IDX, 0, 4'h1);
        chk_val("aux re-reset", rd, 32'h00);
        chk_val("map re-reset", boot_flash_map, 0);
        chk_val("ptr re-reset", xdata_addr, 0);
        $display("test rereset done");
        final_report();
    end
endmodule

bind ddp_aux_ctrl ddp_aux_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (.core_clk,
    .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
    .response, .waitrequest, .ptr_op, .aux_inc, .code_addr,
    .boot_jump_config, .xdata_addr, .pointer_select, .user_flag_three,
    .boot_flash_map, .boot_hit);
`default_nettype wire
